// file: pkg/fsu_defs.vh
`ifndef FSU_DEFS_VH
`define FSU_DEFS_VH

// user command codes
`define FSU_CMD_FORMAT      2'h0
`define FSU_CMD_SHUTDOWN    2'h1
`define FSU_CMD_WRITE       2'h2
`define FSU_CMD_READ        2'h3

// storage controller command codes
`define FSU_SCMD_IDENTIFY   3'h0
`define FSU_SCMD_SHUTDOWN   3'h1
`define FSU_SCMD_WRITE      3'h2
`define FSU_SCMD_READ       3'h3

// register byte offsets
`define FSU_REG_CTRL        7'h00
`define FSU_REG_FILE_NAME   7'h04
`define FSU_REG_FILE_LEN    7'h08
`define FSU_REG_STATUS      7'h0C
`define FSU_REG_FILE_COUNT  7'h10
`define FSU_REG_ERR_CAUSE   7'h14
`define FSU_REG_VERSION     7'h18
`define FSU_REG_SUBMIT_BASE 7'h40

// control field positions
`define FSU_CTRL_CODE_LO    0
`define FSU_CTRL_CODE_HI    1
`define FSU_CTRL_GO         8

// error cause fields
`define FSU_ERR_STORE_HI    23
`define FSU_ERR_CAP_BIT     24
`define FSU_ERR_LBA_BIT     25

// capacity limits in 512-byte blocks: 8 GB and 64 PB
`define FSU_CAP_MIN_BLOCKS  48'h0000_0100_0000
`define FSU_CAP_MAX_BIT     47

// blocks per file, one 32 MB file in 512-byte blocks
`define FSU_BLOCKS_PER_FILE 48'h0000_0001_0000

// data path
`define FSU_BURST_WORDS     6'h20
`define FSU_TX_LEVEL_LO     5
`define FSU_RX_FULL_LO      6
`define FSU_COUNT_MSB       15

// version word, value is arbitrary
`define FSU_VERSION_WORD    32'h0001_0000
// file count shown after initialisation
`define FSU_INIT_FILE_COUNT 27'h000_0000

`endif

// file: rtl/fsu_tx_burst.v
`timescale 1ns/1ps
`include "fsu_defs.vh"

// write-file data path: fetch 32-word bursts from the user fifo, hand to storage
module fsu_tx_burst (
	mclk,
	rst_b,
	enable,
	tx_fifo_level,
	tx_fifo_pop,
	tx_fifo_pop_data,
	store_tx_level,
	store_tx_empty_flag,
	store_tx_pop,
	store_tx_pop_data
);
	input  wire         mclk;
	input  wire         rst_b;
	input  wire         enable;
	input  wire [15:0]  tx_fifo_level;
	output wire         tx_fifo_pop;
	input  wire [127:0] tx_fifo_pop_data;
	output wire [15:0]  store_tx_level;
	output wire         store_tx_empty_flag;
	input  wire         store_tx_pop;
	output reg  [127:0] store_tx_pop_data;

	reg [127:0] buf_mem [0:31];
	reg         pop_ff;
	reg         land_ff;
	reg [5:0]   pop_cnt_ff;
	reg [4:0]   wr_ptr_ff;
	reg [4:0]   rd_ptr_ff;
	reg [5:0]   words_ff;
	wire        start;
	wire        take;

	// burst starts only on a drained buffer and 512 bytes waiting
	assign start = enable & ~pop_ff & ~land_ff & (words_ff == 6'h00) &
		(|tx_fifo_level[`FSU_COUNT_MSB:`FSU_TX_LEVEL_LO]);
	assign tx_fifo_pop = pop_ff;
	assign take = store_tx_pop & (words_ff != 6'h00);
	assign store_tx_level = {10'h000, words_ff};
	assign store_tx_empty_flag = (words_ff == 6'h00);

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pop_ff     <= 1'b0;
			land_ff    <= 1'b0;
			pop_cnt_ff <= 6'h00;
			wr_ptr_ff  <= 5'h00;
			rd_ptr_ff  <= 5'h00;
			words_ff   <= 6'h00;
			store_tx_pop_data <= 128'h0;
		end else begin
			land_ff <= pop_ff;
			if (start) begin
				pop_ff     <= 1'b1;
				pop_cnt_ff <= 6'h00;
			end else if (pop_ff) begin
				pop_cnt_ff <= pop_cnt_ff + 6'h01;
				if (pop_cnt_ff == `FSU_BURST_WORDS - 6'h01) begin
					pop_ff <= 1'b0;
				end
			end
			if (land_ff) begin
				buf_mem[wr_ptr_ff] <= tx_fifo_pop_data;
				wr_ptr_ff <= wr_ptr_ff + 5'h01;
			end
			if (take) begin
				store_tx_pop_data <= buf_mem[rd_ptr_ff];
				rd_ptr_ff <= rd_ptr_ff + 5'h01;
			end
			words_ff <= words_ff + {5'h00, land_ff} - {5'h00, take};
		end
	end
endmodule // fsu_tx_burst

// file: rtl/fsu_rx_relay.v
`timescale 1ns/1ps
`include "fsu_defs.vh"

// read-file data path: storage pushes are relayed into the user rx fifo
module fsu_rx_relay (
	mclk,
	rst_b,
	enable,
	rx_fifo_fill_count,
	rx_fifo_push,
	rx_fifo_push_data,
	store_rx_fill_count,
	store_rx_push,
	store_rx_push_data
);
	input  wire         mclk;
	input  wire         rst_b;
	input  wire         enable;
	input  wire [15:0]  rx_fifo_fill_count;
	output reg          rx_fifo_push;
	output reg  [127:0] rx_fifo_push_data;
	output wire [15:0]  store_rx_fill_count;
	input  wire         store_rx_push;
	input  wire [127:0] store_rx_push_data;

	wire room;

	// the user fifo counter throttles storage directly
	assign store_rx_fill_count = rx_fifo_fill_count;
	assign room = ~(&rx_fifo_fill_count[`FSU_COUNT_MSB:`FSU_RX_FULL_LO]);

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rx_fifo_push      <= 1'b0;
			rx_fifo_push_data <= 128'h0;
		end else begin
			rx_fifo_push <= enable & room & store_rx_push;
			if (store_rx_push) begin
				rx_fifo_push_data <= store_rx_push_data;
			end
		end
	end
endmodule // fsu_rx_relay

// file: rtl/fsu_file_store.v
// How it works
// - available_file_count is a 27-bit count of files on the drive.
// - the file count updates only when init, write-file or format ends, busy low.
// - error_flag rises whenever the error cause vector is nonzero.
// - error_flag stays high until reset is applied.
// - cause bits 23:0 copy the storage controller error cause.
// - cause bit 24 flags capacity of 64 PB or more, or under 8 GB.
// - cause bit 25 flags a logical block size other than 512 bytes.
// - rx fifo pushes only while fill count bits 15:6 are not all ones.
// - read-file data from storage is pushed into the rx fifo.
// - rx push data is valid in each cycle the push strobe is high.
// - the tx fifo empty input is ignored; the level is used instead.
// - write-file data is popped from the tx fifo toward storage.
// - drive storage command, address, length, request; watch its busy.
// - take storage block count, block mode, error flag and error cause.
// - drive sixteen 32-bit custom submission words to storage.
// - drive storage fifo counts, empty and data; take its strobes.
// - a 64-bit test point bus shows sequencer state, init flag, op code, store busy and tx empty in its top 8 bits.
// - each write burst waits for tx level bits 15:5 nonzero.
// - each write burst pops for exactly 32 consecutive cycles.
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "fsu_defs.vh"

module fsu_file_store (
	mclk,
	rst_b,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_byteenable,
	avs_readdata,
	avs_waitrequest,
	command_request,
	command_code,
	core_busy,
	available_file_count,
	error_flag,
	error_cause_vector,
	core_version_word,
	test_point_bus,
	rx_fifo_fill_count,
	rx_fifo_push,
	rx_fifo_push_data,
	tx_fifo_level,
	tx_fifo_empty_flag,
	tx_fifo_pop,
	tx_fifo_pop_data,
	store_command,
	store_address,
	store_length,
	store_request,
	store_busy,
	store_block_count,
	store_block_mode,
	custom_submit_words,
	store_error_flag,
	store_error_cause,
	store_rx_fill_count,
	store_rx_push,
	store_rx_push_data,
	store_tx_level,
	store_tx_empty_flag,
	store_tx_pop,
	store_tx_pop_data
);
	input  wire         mclk;
	input  wire         rst_b;
	input  wire [6:0]   avs_address;
	input  wire         avs_read;
	input  wire         avs_write;
	input  wire [31:0]  avs_writedata;
	input  wire [3:0]   avs_byteenable;
	output reg  [31:0]  avs_readdata;
	output wire         avs_waitrequest;
	input  wire         command_request;
	input  wire [1:0]   command_code;
	output wire         core_busy;
	output reg  [26:0]  available_file_count;
	output reg          error_flag;
	output reg  [31:0]  error_cause_vector;
	output wire [31:0]  core_version_word;
	output reg  [63:0]  test_point_bus;
	input  wire [15:0]  rx_fifo_fill_count;
	output wire         rx_fifo_push;
	output wire [127:0] rx_fifo_push_data;
	input  wire [15:0]  tx_fifo_level;
	input  wire         tx_fifo_empty_flag;
	output wire         tx_fifo_pop;
	input  wire [127:0] tx_fifo_pop_data;
	output reg  [2:0]   store_command;
	output reg  [47:0]  store_address;
	output reg  [47:0]  store_length;
	output reg          store_request;
	input  wire         store_busy;
	input  wire [47:0]  store_block_count;
	input  wire         store_block_mode;
	output wire [511:0] custom_submit_words;
	input  wire         store_error_flag;
	input  wire [31:0]  store_error_cause;
	output wire [15:0]  store_rx_fill_count;
	input  wire         store_rx_push;
	input  wire [127:0] store_rx_push_data;
	output wire [15:0]  store_tx_level;
	output wire         store_tx_empty_flag;
	input  wire         store_tx_pop;
	output wire [127:0] store_tx_pop_data;

	localparam ST_INIT_REQ = 3'h0;
	localparam ST_ACCEPT   = 3'h1;
	localparam ST_RUN      = 3'h2;
	localparam ST_IDLE     = 3'h3;
	localparam ST_ISSUE    = 3'h4;
	localparam ST_DONE     = 3'h5;

	// register bus state
	reg         ack_ff;
	reg [1:0]   ctrl_code_ff;
	reg         go_ff;
	reg [26:0]  file_name_ff;
	reg [26:0]  file_len_ff;
	reg [31:0]  submit_ff [0:15];

	// command state
	reg [2:0]   state_ff;
	reg [2:0]   nxt_state;
	reg [1:0]   op_ff;
	reg         init_ff;
	reg [26:0]  op_name_ff;
	reg [26:0]  op_len_ff;
	reg         cap_err_ff;
	reg         lba_err_ff;
	reg [31:0]  nxt_readdata;

	wire        bus_req;
	wire        wr_now;
	wire        take_cmd;
	wire        write_run;
	wire        read_run;
	wire [47:0] name_wide;
	wire [47:0] len_wide;
	wire [31:0] status_word;
	wire [31:0] name_merge;
	wire [31:0] len_merge;

	// merge byte lanes of a write into an old word
	function [31:0] lane_merge;
		input [31:0] old_word;
		input [31:0] new_word;
		input [3:0]  lanes;
		integer k;
		begin
			lane_merge = old_word;
			for (k = 0; k < 4; k = k + 1) begin
				if (lanes[k]) begin
					lane_merge[k*8 +: 8] = new_word[k*8 +: 8];
				end
			end
		end
	endfunction

	// word-address match ignoring the byte bits
	function hit;
		input [6:0] addr;
		input [6:0] offset;
		begin
			hit = (addr[6:2] == offset[6:2]);
		end
	endfunction

	// bus slave: one wait cycle, answer at the second edge
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_ff;
	assign wr_now = avs_write & ack_ff;

	assign core_busy = (state_ff != ST_IDLE);
	assign take_cmd = (state_ff == ST_IDLE) & (command_request | go_ff);
	assign write_run = (state_ff == ST_RUN) & ~init_ff & (op_ff == `FSU_CMD_WRITE);
	assign read_run = (state_ff == ST_RUN) & ~init_ff & (op_ff == `FSU_CMD_READ);
	assign name_wide = {21'h000000, op_name_ff};
	assign len_wide = {21'h000000, op_len_ff};
	assign core_version_word = `FSU_VERSION_WORD;
	assign status_word = {30'h0, error_flag, core_busy};
	assign name_merge = lane_merge({5'h00, file_name_ff}, avs_writedata, avs_byteenable);
	assign len_merge = lane_merge({5'h00, file_len_ff}, avs_writedata, avs_byteenable);

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ack_ff       <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
			if (avs_read & ~ack_ff) begin
				avs_readdata <= nxt_readdata;
			end
		end
	end

	always @* begin
		nxt_readdata = 32'h0;
		if (avs_address[6]) begin
			nxt_readdata = submit_ff[avs_address[5:2]];
		end else if (hit(avs_address, `FSU_REG_CTRL)) begin
			nxt_readdata = {23'h0, go_ff, 6'h00, ctrl_code_ff};
		end else if (hit(avs_address, `FSU_REG_FILE_NAME)) begin
			nxt_readdata = {5'h00, file_name_ff};
		end else if (hit(avs_address, `FSU_REG_FILE_LEN)) begin
			nxt_readdata = {5'h00, file_len_ff};
		end else if (hit(avs_address, `FSU_REG_STATUS)) begin
			nxt_readdata = status_word;
		end else if (hit(avs_address, `FSU_REG_FILE_COUNT)) begin
			nxt_readdata = {5'h00, available_file_count};
		end else if (hit(avs_address, `FSU_REG_ERR_CAUSE)) begin
			nxt_readdata = error_cause_vector;
		end else if (hit(avs_address, `FSU_REG_VERSION)) begin
			nxt_readdata = core_version_word;
		end
	end

	// control, file name and length registers
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_code_ff <= 2'h0;
			go_ff        <= 1'b0;
			file_name_ff <= 27'h0;
			file_len_ff  <= 27'h0;
		end else begin
			if (take_cmd) begin
				go_ff <= 1'b0;
			end
			if (wr_now & ~avs_address[6]) begin
				if (hit(avs_address, `FSU_REG_CTRL) & avs_byteenable[0]) begin
					ctrl_code_ff <= avs_writedata[`FSU_CTRL_CODE_HI:`FSU_CTRL_CODE_LO];
				end
				if (hit(avs_address, `FSU_REG_CTRL) & avs_byteenable[1] &
					avs_writedata[`FSU_CTRL_GO]) begin
					go_ff <= 1'b1;
				end
				if (hit(avs_address, `FSU_REG_FILE_NAME)) begin
					file_name_ff <= name_merge[26:0];
				end
				if (hit(avs_address, `FSU_REG_FILE_LEN)) begin
					file_len_ff <= len_merge[26:0];
				end
			end
		end
	end

	// custom submission words, one register each
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi = gi + 1) begin : g_submit
			always @(posedge mclk or negedge rst_b) begin
				if (!rst_b) begin
					submit_ff[gi] <= 32'h0;
				end else if (wr_now & avs_address[6] & (avs_address[5:2] == gi)) begin
					submit_ff[gi] <= lane_merge(submit_ff[gi], avs_writedata,
						avs_byteenable);
				end
			end
			assign custom_submit_words[gi*32 +: 32] = submit_ff[gi];
		end
	endgenerate

	// command sequencer
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_INIT_REQ: nxt_state = ST_ACCEPT;
			ST_ISSUE:    nxt_state = ST_ACCEPT;
			ST_ACCEPT: begin
				if (store_busy) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (~store_busy) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: nxt_state = ST_IDLE;
			ST_IDLE: begin
				if (take_cmd) begin
					if ((command_request ? command_code : ctrl_code_ff) == `FSU_CMD_FORMAT) begin
						nxt_state = ST_DONE;
					end else begin
						nxt_state = ST_ISSUE;
					end
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff      <= ST_INIT_REQ;
			op_ff         <= 2'h0;
			init_ff       <= 1'b1;
			op_name_ff    <= 27'h0;
			op_len_ff     <= 27'h0;
			store_command <= `FSU_SCMD_IDENTIFY;
			store_address <= 48'h0;
			store_length  <= 48'h0;
			store_request <= 1'b0;
			available_file_count <= 27'h0;
		end else begin
			state_ff      <= nxt_state;
			store_request <= 1'b0;
			if (state_ff == ST_INIT_REQ) begin
				store_command <= `FSU_SCMD_IDENTIFY;
				store_request <= 1'b1;
			end
			if (take_cmd) begin
				op_ff      <= command_request ? command_code : ctrl_code_ff;
				op_name_ff <= file_name_ff;
				op_len_ff  <= file_len_ff;
			end
			if (state_ff == ST_ISSUE) begin
				store_request <= 1'b1;
				store_address <= name_wide * `FSU_BLOCKS_PER_FILE;
				store_length  <= len_wide * `FSU_BLOCKS_PER_FILE;
				case (op_ff)
					`FSU_CMD_SHUTDOWN: store_command <= `FSU_SCMD_SHUTDOWN;
					`FSU_CMD_WRITE:    store_command <= `FSU_SCMD_WRITE;
					`FSU_CMD_READ:     store_command <= `FSU_SCMD_READ;
					default:           store_command <= `FSU_SCMD_IDENTIFY;
				endcase
			end
			if (state_ff == ST_DONE) begin
				init_ff <= 1'b0;
				if (init_ff) begin
					available_file_count <= `FSU_INIT_FILE_COUNT;
				end else if (op_ff == `FSU_CMD_WRITE) begin
					available_file_count <= op_name_ff + op_len_ff;
				end else if (op_ff == `FSU_CMD_FORMAT) begin
					available_file_count <= 27'h0;
				end
			end
		end
	end

	// error cause and sticky flag
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cap_err_ff <= 1'b0;
			lba_err_ff <= 1'b0;
			error_cause_vector <= 32'h0;
			error_flag <= 1'b0;
		end else begin
			if ((state_ff == ST_DONE) & init_ff) begin
				cap_err_ff <= store_block_count[`FSU_CAP_MAX_BIT] |
					(store_block_count < `FSU_CAP_MIN_BLOCKS);
				lba_err_ff <= store_block_mode;
			end
			error_cause_vector <= {6'h00, lba_err_ff, cap_err_ff,
				store_error_cause[`FSU_ERR_STORE_HI:0]};
			if ((|error_cause_vector) | store_error_flag) begin
				error_flag <= 1'b1;
			end
		end
	end

	// observation only; the tx empty input feeds nothing else
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			test_point_bus <= 64'h0;
		end else begin
			test_point_bus <= {state_ff, init_ff, op_ff, store_busy, tx_fifo_empty_flag,
				56'h0};
		end
	end

	fsu_tx_burst u_tx (
		.mclk               (mclk),
		.rst_b              (rst_b),
		.enable             (write_run),
		.tx_fifo_level      (tx_fifo_level),
		.tx_fifo_pop        (tx_fifo_pop),
		.tx_fifo_pop_data   (tx_fifo_pop_data),
		.store_tx_level     (store_tx_level),
		.store_tx_empty_flag(store_tx_empty_flag),
		.store_tx_pop       (store_tx_pop),
		.store_tx_pop_data  (store_tx_pop_data)
	);

	fsu_rx_relay u_rx (
		.mclk               (mclk),
		.rst_b              (rst_b),
		.enable             (read_run),
		.rx_fifo_fill_count (rx_fifo_fill_count),
		.rx_fifo_push       (rx_fifo_push),
		.rx_fifo_push_data  (rx_fifo_push_data),
		.store_rx_fill_count(store_rx_fill_count),
		.store_rx_push      (store_rx_push),
		.store_rx_push_data (store_rx_push_data)
	);
endmodule // fsu_file_store

// file: tb/fsu_file_store_asserts.sv
`timescale 1ns/1ps
`include "fsu_defs.vh"
module fsu_chk (
	input logic         mclk,
	input logic         rst_b,
	input logic         command_request,
	input logic [1:0]   command_code,
	input logic         core_busy,
	input logic [26:0]  available_file_count,
	input logic         error_flag,
	input logic [31:0]  error_cause_vector,
	input logic [15:0]  rx_fifo_fill_count,
	input logic         rx_fifo_push,
	input logic [127:0] rx_fifo_push_data,
	input logic [15:0]  tx_fifo_level,
	input logic         tx_fifo_pop,
	input logic [2:0]   store_command,
	input logic         store_request,
	input logic [31:0]  store_error_cause,
	input logic         store_rx_push,
	input logic [127:0] store_rx_push_data
);
	logic [6:0] pop_run_ff;
	// length of the current tx pop run
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			pop_run_ff <= 7'h00;
		else
			pop_run_ff <= tx_fifo_pop ? pop_run_ff + 7'h01 : 7'h00;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_burst_len: assert property ($fell(tx_fifo_pop) |-> pop_run_ff == 7'h20)
		else $error("tx pop burst length wrong");
	a_burst_start: assert property ($rose(tx_fifo_pop) |-> $past(tx_fifo_level[15:5]) != 11'h0)
		else $error("tx burst began without a full block");
	a_rx_guard: assert property (rx_fifo_push |-> !$past(&rx_fifo_fill_count[15:6]))
		else $error("rx push while rx fifo full");
	a_rx_relay: assert property (rx_fifo_push |->
		$past(store_rx_push) && rx_fifo_push_data == $past(store_rx_push_data))
		else $error("rx push data not relayed");
	a_cmd_issue: assert property (!core_busy && command_request &&
		command_code != `FSU_CMD_FORMAT |=> core_busy ##1
		store_request && store_command == {1'b0, $past(command_code, 2)})
		else $error("store command not issued");
	a_err_raise: assert property (|error_cause_vector |=> error_flag)
		else $error("error flag missing");
	a_err_sticky: assert property (error_flag |=> error_flag)
		else $error("error flag dropped");
	a_cause_copy: assert property (1'b1 |=>
		error_cause_vector[23:0] == $past(store_error_cause[23:0]))
		else $error("error cause not copied");
	a_count_hold: assert property (!core_busy && !$past(core_busy) |->
		$stable(available_file_count))
		else $error("file count changed while idle");
	cover property ($fell(tx_fifo_pop));
	cover property (rx_fifo_push);
	cover property (store_request && store_command == `FSU_SCMD_READ);
endmodule // fsu_chk
bind fsu_file_store fsu_chk u_chk (.mclk, .rst_b, .command_request, .command_code, .core_busy,
	.available_file_count, .error_flag, .error_cause_vector, .rx_fifo_fill_count, .rx_fifo_push,
	.rx_fifo_push_data, .tx_fifo_level, .tx_fifo_pop, .store_command, .store_request,
	.store_error_cause, .store_rx_push, .store_rx_push_data);

// file: tb/fsu_store_model.sv
`timescale 1ns/1ps
// storage controller stand-in: busy window per request, moves data both ways
module fsu_store_model (
	input  logic         mclk,
	input  logic         rst_b,
	input  logic         store_request,
	input  logic [2:0]   store_command,
	output logic         store_busy,
	input  logic [15:0]  store_tx_level,
	output logic         store_tx_pop,
	output logic         store_rx_push,
	output logic [127:0] store_rx_push_data
);
	logic [2:0] op_ff;
	logic [5:0] cnt_ff;
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			{store_busy, store_tx_pop, store_rx_push, op_ff, cnt_ff} <= '0;
			store_rx_push_data <= 128'h0;
		end else begin
			store_rx_push <= 1'b0;
			store_tx_pop <= 1'b0;
			store_rx_push_data <= ~store_rx_push_data;
			if (store_request) begin
				store_busy <= 1'b1;
				op_ff <= store_command;
				cnt_ff <= 6'h00;
			end else if (store_busy) begin
				// read: eight back-to-back words
				if (op_ff == 3'h3 && cnt_ff < 6'h08) begin
					store_rx_push <= 1'b1;
					store_rx_push_data <= {$urandom, $urandom, $urandom, $urandom};
				end
				// write: pop every other cycle so the level is never stale
				if (op_ff == 3'h2 && store_tx_level != 16'h0 && !store_tx_pop)
					store_tx_pop <= 1'b1;
				if (op_ff != 3'h2 || store_tx_pop)
					cnt_ff <= cnt_ff + 6'h01;
				if (cnt_ff == (op_ff == 3'h2 ? 6'h20 : 6'h0C))
					store_busy <= 1'b0;
			end
		end
	end
endmodule // fsu_store_model

// file: tb/tb.sv
`timescale 1ns/1ps
`include "fsu_defs.vh"
module tb;
	logic         mclk, rst_b, avs_read, avs_write, avs_waitrequest, pop_d;
	logic [6:0]   avs_address;
	logic [31:0]  avs_writedata, avs_readdata, error_cause_vector, core_version_word;
	logic [31:0]  store_error_cause, rd, w;
	logic [3:0]   avs_byteenable;
	logic         command_request, core_busy, error_flag, rx_fifo_push, tx_fifo_empty_flag;
	logic         tx_fifo_pop, store_request, store_busy, store_block_mode, store_error_flag;
	logic         store_rx_push, store_tx_empty_flag, store_tx_pop;
	logic [1:0]   command_code;
	logic [26:0]  available_file_count;
	logic [63:0]  test_point_bus;
	logic [15:0]  rx_fifo_fill_count, tx_fifo_level, store_rx_fill_count, store_tx_level;
	logic [127:0] rx_fifo_push_data, tx_fifo_pop_data, store_rx_push_data, store_tx_pop_data, txw;
	logic [2:0]   store_command;
	logic [47:0]  store_address, store_length, store_block_count;
	logic [511:0] custom_submit_words;
	logic [99:0]  ec;
	logic [127:0] q_rx[$], q_tx[$];
	logic [99:0]  q_cmd[$];
	logic [48:0]  cap_tab[3] = '{{48'h0000_00FF_FFFF, 1'b1}, {48'h8000_0000_0000, 1'b0},
		{48'h7FFF_FFFF_FFFF, 1'b0}};
	logic [1:0]   bit_tab[3] = '{2'h3, 2'h1, 2'h0};
	int           failures = 0, n_compared = 0, n_pop = 0, n_rx = 0;
	localparam logic [99:0] RD_EXP = {1'b1, `FSU_SCMD_READ, `FSU_BLOCKS_PER_FILE,
		48'h2 * `FSU_BLOCKS_PER_FILE};

	fsu_file_store u_dut (.mclk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .command_request, .command_code,
		.core_busy, .available_file_count, .error_flag, .error_cause_vector,
		.core_version_word, .test_point_bus, .rx_fifo_fill_count, .rx_fifo_push,
		.rx_fifo_push_data, .tx_fifo_level, .tx_fifo_empty_flag, .tx_fifo_pop,
		.tx_fifo_pop_data, .store_command, .store_address, .store_length, .store_request,
		.store_busy, .store_block_count, .store_block_mode, .custom_submit_words,
		.store_error_flag, .store_error_cause, .store_rx_fill_count, .store_rx_push,
		.store_rx_push_data, .store_tx_level, .store_tx_empty_flag, .store_tx_pop,
		.store_tx_pop_data);
	fsu_store_model u_model (.mclk, .rst_b, .store_request, .store_command, .store_busy,
		.store_tx_level, .store_tx_pop, .store_rx_push, .store_rx_push_data);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		if (n == 20) failures++;
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		while (core_busy !== 1'b0 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		if (n == 3000) failures++;
	endtask

	task automatic cmd(input logic [1:0] c, input logic [99:0] exp);
		wait_idle;
		if (c != `FSU_CMD_FORMAT) q_cmd.push_back(exp);
		command_code <= c;
		command_request <= 1'b1;
		@(posedge mclk);
		command_request <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic reset_dut(input logic [47:0] blocks, input logic mode);
		rst_b <= 1'b0;
		store_block_count <= blocks;
		store_block_mode <= mode;
		repeat (4) @(posedge mclk);
		chk(error_flag, 1'b0);
		q_cmd.push_back({1'b0, `FSU_SCMD_IDENTIFY, 96'h0});
		rst_b <= 1'b1;
		@(posedge mclk);
		wait_idle;
		repeat (2) @(posedge mclk);
	endtask

	// result watcher and user fifo stand-ins
	always @(posedge mclk) begin
		if (store_request === 1'b1) begin
			ec = q_cmd.pop_front();
			chk(store_command, ec[98:96]);
			if (ec[99]) chk({store_address, store_length}, ec[95:0]);
		end
		if (rx_fifo_push === 1'b1) begin
			n_rx++;
			chk(rx_fifo_push_data, q_rx.pop_front());
		end
		if (store_rx_push === 1'b1 && !(&rx_fifo_fill_count[15:6]))
			q_rx.push_back(store_rx_push_data);
		if (tx_fifo_pop === 1'b1) begin
			n_pop++;
			txw = {$urandom, $urandom, $urandom, $urandom};
			tx_fifo_pop_data <= txw;
			q_tx.push_back(txw);
			tx_fifo_level <= tx_fifo_level - 16'h1;
		end else
			tx_fifo_pop_data <= ~tx_fifo_pop_data;
		if (pop_d) chk(store_tx_pop_data, q_tx.pop_front());
		pop_d <= store_tx_pop;
	end

	initial begin
		#200us;
		failures++;
		report_and_stop;
	end

	initial begin
		rst_b = 1'b0;
		{avs_address, avs_read, avs_write, avs_writedata, pop_d} = '0;
		{command_request, command_code, store_error_flag, store_error_cause} = '0;
		{rx_fifo_fill_count, tx_fifo_level, tx_fifo_pop_data} = '0;
		avs_byteenable = 4'hF;
		tx_fifo_empty_flag = 1'b1;
		store_block_count = `FSU_CAP_MIN_BLOCKS;
		store_block_mode = 1'b0;
		void'($urandom(56));
		reset_dut(`FSU_CAP_MIN_BLOCKS, 1'b0);
		chk(error_cause_vector, 32'h0);
		chk(available_file_count, 27'h0);
		bus(1'b0, `FSU_REG_STATUS, 32'h0);
		chk(rd[1:0], 2'h0);
		bus(1'b0, 7'h20, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 16; i += 15) begin
			w = $urandom;
			bus(1'b1, `FSU_REG_SUBMIT_BASE + 7'(i * 4), w);
			chk(custom_submit_words[i * 32 +: 32], w);
		end
		$display("test init and registers done");
		bus(1'b1, `FSU_REG_FILE_NAME, 32'h0);
		bus(1'b1, `FSU_REG_FILE_LEN, 32'h3);
		tx_fifo_level <= 16'h001F;
		cmd(`FSU_CMD_WRITE, {1'b1, `FSU_SCMD_WRITE, 48'h0, 48'h3 * `FSU_BLOCKS_PER_FILE});
		repeat (40) @(posedge mclk);
		chk(n_pop, 0);
		chk({store_tx_level, store_tx_empty_flag}, 17'h1);
		tx_fifo_level <= 16'h0020;
		wait_idle;
		chk(n_pop, 32);
		chk(available_file_count, 27'h3);
		$display("test write file done");
		bus(1'b1, `FSU_REG_FILE_NAME, 32'h1);
		bus(1'b1, `FSU_REG_FILE_LEN, 32'h2);
		rx_fifo_fill_count <= 16'hFFBF;
		cmd(`FSU_CMD_READ, RD_EXP);
		wait_idle;
		chk(store_rx_fill_count, 16'hFFBF);
		rx_fifo_fill_count <= 16'hFFC0;
		cmd(`FSU_CMD_READ, RD_EXP);
		wait_idle;
		chk(n_rx, 8);
		chk(available_file_count, 27'h3);
		$display("test read file done");
		cmd(`FSU_CMD_SHUTDOWN, {1'b0, `FSU_SCMD_SHUTDOWN, 96'h0});
		cmd(`FSU_CMD_FORMAT, 100'h0);
		wait_idle;
		chk(available_file_count, 27'h0);
		$display("test shutdown and format done");
		w = $urandom | 32'h1;
		store_error_cause <= {8'h00, w[23:0]};
		repeat (3) @(posedge mclk);
		chk(error_cause_vector[23:0], w[23:0]);
		chk(error_flag, 1'b1);
		store_error_cause <= 32'h0;
		repeat (3) @(posedge mclk);
		chk(error_flag, 1'b1);
		$display("test error cause done");
		for (int i = 0; i < 3; i++) begin
			reset_dut(cap_tab[i][48:1], cap_tab[i][0]);
			chk(error_cause_vector[25:24], bit_tab[i]);
			chk(error_flag, |bit_tab[i]);
		end
		store_error_flag <= 1'b1;
		repeat (3) @(posedge mclk);
		chk({error_flag, error_cause_vector}, 33'h1_0000_0000);
		$display("test capacity and block size done");
		report_and_stop;
	end
endmodule // tb
